// >>> design/dtb_debug.sv
/*
 * dtb_debug: trace buffer, readout lock, opcode tagging and breakpoint
 * sequencing of the on-chip debug block, Avalon-MM register slave.
 * Assumes cpu inputs are synchronous to clk and the comparators and
 * state sequencer outside flag which matches lead to the final state.
 */
`timescale 1ns/100ps
module dtb_debug import dtb_pkg::*; #(
    parameter int DEPTH = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire dtb_cpu_s cpu,
    input wire logic background_monitor,
    input wire logic sys_secured,
    output dtb_tag_s tag,
    output logic break_req,
    output logic trace_active
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    // refused at elaboration: pointers wrap by overflow only
    if (DEPTH < 2 || (1 << AW) != DEPTH || CW > DTB_CNT_W)
    begin : g_depth_check
        $error("DEPTH must be a power of two from 2 to 32768");
    end

    typedef struct packed {
        dtb_seq_e fsm;
        logic tsrc;
        logic ibrk;
        logic align_begin;
        logic brk_en;
        logic [2:0] tag_sel;
        logic unlocked;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
        logic wrap;
        logic fresh;
        logic half;
        logic ack;
        logic [31:0] rdata;
        dtb_tag_s tag;
    } dtb_state_s;

    dtb_state_s r_reg;
    dtb_state_s r_next;
    dtb_state_s rst_val;
    dtb_line_s ram_rdata;
    dtb_line_s pk_line;
    logic pk_wr;
    logic pk_new;
    logic pk_start;
    logic go;
    logic word_acc;
    logic readable;
    logic sw_software_trigger_bit;
    logic final_hit;
    logic software_trigger_bit;
    logic immediate_break_bit;
    logic [AW-1:0] oldest;
    logic [AW-1:0] waddr;

    assign avs_waitrequest = (avs_read || avs_write) && !r_reg.ack;
    assign avs_readdata = r_reg.rdata;
    assign tag = r_reg.tag;
    assign break_req = immediate_break_bit;
    assign trace_active = r_reg.tsrc
        && (r_reg.fsm == DTB_PRE || r_reg.fsm == DTB_POST);
    assign go = (avs_read || avs_write) && !r_reg.ack;
    assign word_acc = avs_byteenable == DTB_BE_WORD;
    assign readable = r_reg.fsm == DTB_IDLE && r_reg.tsrc
        && !sys_secured && r_reg.unlocked;
    assign oldest = r_reg.wrap ? r_reg.wr_ptr + AW'(1) : '0;
    assign waddr = r_reg.fresh ? '0 : r_reg.wr_ptr + AW'(1);

    // comparator path uses qualifiers, tag path ignores them
    assign final_hit = !background_monitor && |(cpu.to_final
        & ((cpu.match & ~r_reg.tag_sel & cpu.qual_ok)
        | (cpu.tag_hit & r_reg.tag_sel)));

    dtb_pc_pack u_pack (
        .clk(clk),
        .rst(rst),
        .start(pk_start),
        .pc_valid(cpu.pc_valid && trace_active),
        .pc(cpu.pc),
        .at_last(!r_reg.fresh && r_reg.wr_ptr == LAST),
        .wr_en(pk_wr),
        .new_line(pk_new),
        .line(pk_line)
    );

    dtb_trace_ram #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_ram (
        .clk(clk),
        .we(pk_wr),
        .waddr(pk_new ? waddr : r_reg.wr_ptr),
        .wdata(pk_line),
        .raddr(r_reg.rd_ptr),
        .rdata(ram_rdata)
    );

    always_comb
    begin
        r_next = r_reg;
        sw_software_trigger_bit = 1'b0;
        pk_start = 1'b0;
        immediate_break_bit = 1'b0;
        software_trigger_bit = 1'b0;
        r_next.ack = go;
        // trace line bookkeeping, lines land in order
        if (pk_wr && pk_new)
        begin
            r_next.wr_ptr = waddr;
            r_next.fresh = 1'b0;
            if (!r_reg.fresh && r_reg.wr_ptr == LAST)
            begin
                r_next.wrap = 1'b1;
            end
            if (r_reg.count != FULL)
            begin
                r_next.count = r_reg.count + CW'(1);
            end
        end
        if (go && avs_read)
        begin
            case (avs_address)
                DTB_OFS_CTRL:
                begin
                    r_next.rdata = '0;
                    r_next.rdata[DTB_C_ARM] = r_reg.fsm != DTB_IDLE;
                    r_next.rdata[DTB_C_IBRK] = r_reg.ibrk;
                    r_next.rdata[DTB_C_ALIGN] = r_reg.align_begin;
                    r_next.rdata[DTB_C_BRKEN] = r_reg.brk_en;
                    r_next.rdata[DTB_C_TSRC] = r_reg.tsrc;
                    r_next.rdata[DTB_C_TAG +: DTB_NCH] = r_reg.tag_sel;
                end
                DTB_OFS_STAT:
                begin
                    r_next.rdata = '0;
                    r_next.rdata[DTB_S_CNT +: DTB_CNT_W] =
                        DTB_CNT_W'(r_reg.count);
                    r_next.rdata[DTB_S_WRAP] = r_reg.wrap;
                    r_next.rdata[DTB_S_ARMED] = r_reg.fsm != DTB_IDLE;
                    r_next.rdata[DTB_S_UNLOCK] = r_reg.unlocked;
                    r_next.rdata[DTB_S_POST] = r_reg.fsm == DTB_POST;
                end
                DTB_OFS_TRACE:
                begin
                    r_next.rdata = '0;
                    if (word_acc && readable)
                    begin
                        if (r_reg.half)
                        begin
                            r_next.rdata[DTB_TOP_W-1:0] = {ram_rdata.info,
                                ram_rdata.data[17:16]};
                            r_next.rd_ptr = r_reg.rd_ptr + AW'(1);
                        end
                        else
                        begin
                            r_next.rdata[DTB_HALF_W-1:0] =
                                ram_rdata.data[15:0];
                        end
                        r_next.half = !r_reg.half;
                    end
                end
                default:
                begin
                    r_next.rdata = '0;
                end
            endcase
        end
        if (go && avs_write)
        begin
            case (avs_address)
                DTB_OFS_CTRL:
                begin
                    if (avs_byteenable[0])
                    begin
                        r_next.tsrc = avs_writedata[DTB_C_TSRC];
                        r_next.ibrk = avs_writedata[DTB_C_IBRK];
                        r_next.align_begin = avs_writedata[DTB_C_ALIGN];
                        r_next.brk_en = avs_writedata[DTB_C_BRKEN];
                        sw_software_trigger_bit = avs_writedata[DTB_C_SOFTWARE_TRIGGER_BIT];
                        if (!avs_writedata[DTB_C_ARM])
                        begin
                            r_next.fsm = DTB_IDLE;
                        end
                        else if (r_reg.fsm == DTB_IDLE)
                        begin
                            r_next.unlocked = 1'b0;
                            if (r_next.tsrc && !r_next.align_begin)
                            begin
                                r_next.fsm = DTB_PRE;
                                pk_start = 1'b1;
                            end
                            else
                            begin
                                r_next.fsm = DTB_WAIT;
                            end
                        end
                    end
                    if (avs_byteenable[1])
                    begin
                        r_next.tag_sel =
                            avs_writedata[DTB_C_TAG +: DTB_NCH];
                    end
                end
                DTB_OFS_TRACE, DTB_OFS_TRACE_UP:
                begin
                    if (word_acc && r_reg.fsm == DTB_IDLE)
                    begin
                        r_next.unlocked = 1'b1;
                        r_next.rd_ptr = oldest;
                        r_next.half = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end
        // trigger acts on the state after any arm write of this cycle
        software_trigger_bit = sw_software_trigger_bit || final_hit;
        case (r_next.fsm)
            DTB_PRE, DTB_WAIT:
            begin
                if (software_trigger_bit)
                begin
                    if (!r_next.tsrc || r_next.ibrk
                        || r_next.fsm == DTB_PRE)
                    begin
                        r_next.fsm = DTB_IDLE;
                        immediate_break_bit = r_next.brk_en;
                    end
                    else
                    begin
                        r_next.fsm = DTB_POST;
                        pk_start = 1'b1;
                    end
                end
            end
            DTB_POST:
            begin
                // once tracing started, later triggers end it only while ibrk is set
                if (r_next.count == FULL || (software_trigger_bit && r_next.ibrk))
                begin
                    r_next.fsm = DTB_IDLE;
                    immediate_break_bit = r_next.brk_en;
                end
            end
            DTB_IDLE:
            begin
            end
            default:
            begin
                r_next.fsm = DTB_IDLE;
            end
        endcase
        if (pk_start)
        begin
            r_next.fresh = 1'b1;
            r_next.wrap = 1'b0;
            r_next.count = '0;
        end
        r_next.tag.tag_req = background_monitor ? '0
            : cpu.match & r_reg.tag_sel;
        r_next.tag.tag_addr = {cpu.match_addr[17:1], 1'b0};
        rst_val = '0;
        rst_val.fsm = DTB_IDLE;
        rst_val.wr_ptr = r_reg.wr_ptr;
        rst_val.count = r_reg.count;
        rst_val.wrap = r_reg.wrap;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r_reg <= rst_val;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);

    a_bus_answer: assert property ((avs_read || avs_write)
        && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer later than one cycle");
    a_arm_locks: assert property (go && avs_write
        && avs_address == DTB_OFS_CTRL && avs_byteenable[0]
        && avs_writedata[DTB_C_ARM] && r_reg.fsm == DTB_IDLE
        |=> !r_reg.unlocked && !avs_waitrequest)
        else $error("arm write left buffer unlocked");
    a_bad_read_zero: assert property (go && avs_read
        && avs_address == DTB_OFS_TRACE && !word_acc
        |=> avs_readdata == '0 && $stable(r_reg.rd_ptr))
        else $error("odd trace read returned data or moved pointer");
    a_armed_read: assert property (go && avs_read
        && avs_address == DTB_OFS_TRACE && r_reg.fsm != DTB_IDLE
        |=> $stable(r_reg.rd_ptr) && $stable(r_reg.half))
        else $error("armed trace read moved pointer");
    a_src_off_zero: assert property (go && avs_read
        && avs_address == DTB_OFS_TRACE && !r_reg.tsrc
        |=> avs_readdata == '0)
        else $error("trace read nonzero with source off");
    a_upper_restart: assert property (go && avs_write
        && avs_address == DTB_OFS_TRACE_UP && word_acc
        && r_reg.fsm == DTB_IDLE
        |=> r_reg.rd_ptr == $past(oldest) && r_reg.unlocked && !r_reg.half)
        else $error("upper word write did not restart readout");
    a_line0_base: assert property (pk_wr && pk_new && waddr == '0
        |-> pk_line.info == DTB_INFO_BASE)
        else $error("line zero written without base");
    a_nosrc_break: assert property (r_reg.fsm == DTB_WAIT
        && !r_reg.tsrc && final_hit && !(go && avs_write)
        |-> break_req == r_reg.brk_en ##1 r_reg.fsm == DTB_IDLE)
        else $error("no immediate break without trace session");
    a_tag_monitor: assert property (background_monitor
        |=> r_reg.tag.tag_req == '0)
        else $error("tag raised while monitor active");
    a_count_hold: assert property (r_reg.fsm == DTB_IDLE
        && !pk_start && !(pk_wr && pk_new) |=> $stable(r_reg.count))
        else $error("line count changed while idle");
endmodule : dtb_debug

// >>> design/dtb_pc_pack.sv
/*
 * dtb_pc_pack: compressed program-counter line encoder.
 * Assumes start comes one cycle ahead of the session's first pc.
 */
`timescale 1ns/100ps
module dtb_pc_pack import dtb_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic pc_valid,
    input wire logic [17:0] pc,
    input wire logic at_last,
    output logic wr_en,
    output logic new_line,
    output dtb_line_s line
);
    typedef struct packed {
        logic [11:0] base;
        logic have_base;
        logic [1:0] nincr;
        logic [17:0] acc;
    } pk_state_s;

    pk_state_s r_reg;
    pk_state_s r_next;
    logic closed;

    always_comb
    begin
        r_next = r_reg;
        wr_en = 1'b0;
        new_line = 1'b0;
        line = '0;
        closed = (r_reg.nincr == 2'h0) || (r_reg.nincr == 2'h3);
        if (start)
        begin
            r_next.have_base = 1'b0;
            r_next.nincr = 2'h0;
        end
        else if (pc_valid)
        begin
            wr_en = 1'b1;
            if (!r_reg.have_base || pc[17:6] != r_reg.base
                || (closed && at_last))
            begin
                new_line = 1'b1;
                line = '{info: DTB_INFO_BASE, data: pc};
                r_next.base = pc[17:6];
                r_next.have_base = 1'b1;
                r_next.nincr = 2'h0;
            end
            else if (closed)
            begin
                new_line = 1'b1;
                r_next.acc = {12'h000, pc[5:0]};
                r_next.nincr = DTB_INFO_ONE;
                line = '{info: DTB_INFO_ONE, data: r_next.acc};
            end
            else
            begin
                // increments fill upward, info equals the count
                if (r_reg.nincr == DTB_INFO_ONE)
                begin
                    r_next.acc[11:6] = pc[5:0];
                end
                else
                begin
                    r_next.acc[17:12] = pc[5:0];
                end
                r_next.nincr = r_reg.nincr + 2'h1;
                line = '{info: r_next.nincr, data: r_next.acc};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end
endmodule : dtb_pc_pack

// >>> design/dtb_pkg.sv
/*
 * dtb_pkg: register map, field positions, line encoding, sequencer states
 * and carrier structs of the debug trace / tag / breakpoint block.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package dtb_pkg;
    // register byte offsets
    localparam logic [3:0] DTB_OFS_CTRL = 4'h0;
    localparam logic [3:0] DTB_OFS_STAT = 4'h4;
    localparam logic [3:0] DTB_OFS_TRACE = 4'h8;
    localparam logic [3:0] DTB_OFS_TRACE_UP = 4'hc;
    // debug_control_one bit positions
    localparam int DTB_C_ARM = 0;
    localparam int DTB_C_SOFTWARE_TRIGGER_BIT = 1;
    localparam int DTB_C_IBRK = 2;
    localparam int DTB_C_ALIGN = 3;
    localparam int DTB_C_BRKEN = 4;
    localparam int DTB_C_TSRC = 5;
    localparam int DTB_C_TAG = 8;
    // trace_line_count_reg bit positions
    localparam int DTB_S_CNT = 0;
    localparam int DTB_S_WRAP = 16;
    localparam int DTB_S_ARMED = 17;
    localparam int DTB_S_UNLOCK = 18;
    localparam int DTB_S_POST = 19;
    localparam int DTB_CNT_W = 16;
    // byte enables of an aligned 16-bit word access
    localparam logic [3:0] DTB_BE_WORD = 4'h3;
    localparam int DTB_NCH = 3;
    localparam int DTB_PC_W = 18;
    localparam int DTB_INC_W = 6;
    localparam int DTB_HALF_W = 16;
    localparam int DTB_TOP_W = 4;
    localparam logic [1:0] DTB_INFO_BASE = 2'h0;
    localparam logic [1:0] DTB_INFO_ONE = 2'h1;
    localparam logic [1:0] DTB_INFO_TWO = 2'h2;

    typedef enum logic [3:0] {
        DTB_IDLE = 4'h1,
        DTB_PRE = 4'h2,
        DTB_WAIT = 4'h4,
        DTB_POST = 4'h8
    } dtb_seq_e;

    typedef struct packed {
        logic [1:0] info;
        logic [17:0] data;
    } dtb_line_s;

    typedef struct packed {
        logic [17:0] pc;
        logic pc_valid;
        logic [2:0] match;
        logic [2:0] qual_ok;
        logic [2:0] to_final;
        logic [2:0] tag_hit;
        logic [17:0] match_addr;
    } dtb_cpu_s;

    typedef struct packed {
        logic [2:0] tag_req;
        logic [17:0] tag_addr;
    } dtb_tag_s;
endpackage : dtb_pkg

// >>> design/dtb_trace_ram.sv
/*
 * dtb_trace_ram: trace line storage, one write port, one registered read.
 * Assumes nothing clears it; contents survive reset by intent.
 */
`timescale 1ns/100ps
module dtb_trace_ram import dtb_pkg::*; #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire dtb_line_s wdata,
    input wire logic [AW-1:0] raddr,
    output dtb_line_s rdata
);
    dtb_line_s mem [DEPTH];

    // no reset: pre-reset trace must stay readable
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : dtb_trace_ram

// >>> test/dtb_cpu_model.sv
/*
 * dtb_cpu_model: instruction queue and comparator stand-in for dtb_debug.
 * Assumes the bench requests pcs and matches by level, one per clock.
 */
`timescale 1ns/100ps
module dtb_cpu_model import dtb_pkg::*; #(
    parameter int QDEPTH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pc_req,
    input wire logic [17:0] pc_in,
    input wire logic fire,
    input wire logic qual,
    input wire logic [17:0] addr,
    input wire dtb_tag_s tag,
    output dtb_cpu_s cpu
);
    logic [QDEPTH-1:0][2:0] queue_reg;
    initial cpu = '0;
    initial queue_reg = '0;
    always @(posedge clk)
    begin
        // tags ride the queue and pulse once on reaching its head
        queue_reg <= rst ? '0 : {queue_reg[QDEPTH-2:0], tag.tag_req};
        cpu.tag_hit <= rst ? 3'h0 : queue_reg[QDEPTH-1];
        cpu.pc_valid <= pc_req & ~rst;
        // idle lines toggle so a stale pc never looks valid
        cpu.pc <= pc_req ? pc_in : ~cpu.pc;
        cpu.match <= {2'h0, fire & ~rst};
        cpu.qual_ok <= {3{qual}};
        cpu.to_final <= 3'h1;
        cpu.match_addr <= fire ? addr : ~cpu.match_addr;
    end
endmodule : dtb_cpu_model

// >>> test/dtb_debug_tb.sv
/*
 * dtb_debug_tb: self-checking bench for dtb_debug with a line model.
 * Assumes DEPTH 8 so the trace buffer wraps in a short run.
 */
`timescale 1ns/100ps
module dtb_debug_tb import dtb_pkg::*;;
    localparam int D = 8;
    logic clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic background_monitor = 0, sys_secured = 0, trace_active;
    logic pc_req = 0, fire = 0, qual = 0, avs_waitrequest, break_req;
    logic [3:0] avs_address = '0, avs_byteenable = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, v;
    logic [17:0] pc_in = '0, addr = '0, seen_addr = '0;
    logic [11:0] hi = 12'h0a5, bhi = '0;
    logic [19:0] mem [D];
    dtb_cpu_s cpu;
    dtb_tag_s tag;
    int bad_count = 0, n_compared = 0, cyc = 0, brk_n = 0, n0;
    int seed = 62597, cur = 0, fill = 0, wrapped = 0, first = 1;

    dtb_debug #(.DEPTH(D)) i_dtb_debug (.clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .cpu, .background_monitor, .sys_secured, .tag,
        .break_req, .trace_active);
    dtb_cpu_model #(.QDEPTH(3)) i_dtb_cpu_model (.clk, .rst, .pc_req, .pc_in,
        .fire, .qual, .addr, .tag, .cpu);

    always #25 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (!rst && break_req === 1'b1) brk_n++;
        if (tag.tag_req !== 3'h0) seen_addr <= tag.tag_addr;
        if (cyc == 5000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    function automatic void chk(input string n, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endfunction : chk

    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        // waitrequest and read data are taken at the same rising edge
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask : bus

    // one pc into the design, and into the line model
    task automatic put(input logic [17:0] p);
        int nxt;
        @(posedge clk);
        pc_req <= 1;
        pc_in <= p;
        nxt = first ? 0 : (cur + 1) % D;
        if (first || p[17:6] != bhi || fill == 0 || fill == 3)
        begin
            if (nxt == 0 && !first) wrapped = 1;
            if (first || p[17:6] != bhi || nxt == 0)
            begin
                mem[nxt] = {2'h0, p};
                fill = 0;
                bhi = p[17:6];
            end
            else
            begin
                mem[nxt] = {2'h1, 12'h0, p[5:0]};
                fill = 1;
            end
            cur = nxt;
            first = 0;
        end
        else
        begin
            fill++;
            mem[cur][19:18] = fill[1:0];
            mem[cur][fill*6-1 -: 6] = p[5:0];
        end
    endtask : put

    task automatic burst(input int n);
        logic [31:0] r;
        for (int i = 0; i < n; i++)
        begin
            r = $random(seed);
            if (r[4:0] == 5'h0) hi = hi + 12'h1;
            put({hi, r[10:5]});
        end
        @(posedge clk);
        pc_req <= 0;
    endtask : burst

    task automatic readout();
        int ln;
        bus(1, DTB_OFS_TRACE_UP, 0, DTB_BE_WORD);
        for (int k = 0; k < (wrapped ? D : cur + 1); k++)
        begin
            ln = wrapped ? (cur + 1 + k) % D : k;
            bus(0, DTB_OFS_TRACE, 0, DTB_BE_WORD);
            chk("low word", {16'h0, mem[ln][15:0]}, v);
            bus(0, DTB_OFS_TRACE, 0, 4'h1);
            chk("byte read", 0, v);
            bus(0, DTB_OFS_TRACE, 0, DTB_BE_WORD);
            chk("high word", {28'h0, mem[ln][19:16]}, v);
        end
    endtask : readout

    task automatic hit(input logic q);
        @(posedge clk);
        fire <= 1;
        qual <= q;
        addr <= 18'h23457;
        @(posedge clk);
        fire <= 0;
        repeat (8) @(posedge clk);
    endtask : hit

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 0;
        bus(0, DTB_OFS_CTRL, 0, 4'hf);
        chk("ctrl reset", 0, v);
        bus(1, 4'h2, 32'hffffffff, 4'hf);
        bus(0, 4'h2, 0, 4'hf);
        chk("unmapped", 0, v);
        $display("test registers done");
        bus(1, DTB_OFS_CTRL, 32'h31, 4'hf);
        bus(0, DTB_OFS_TRACE, 0, DTB_BE_WORD);
        chk("armed read", 0, v);
        burst(6);
        bus(1, DTB_OFS_CTRL, 32'h33, 4'hf);
        repeat (2) @(posedge clk);
        chk("end break", 1, brk_n);
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        bus(1, DTB_OFS_CTRL, 32'h20, 4'hf);
        bus(0, DTB_OFS_TRACE, 0, DTB_BE_WORD);
        chk("locked read", 0, v);
        bus(0, DTB_OFS_STAT, 0, 4'hf);
        chk("status", cur + 1, v);
        readout();
        bus(1, DTB_OFS_TRACE_UP, 0, DTB_BE_WORD);
        bus(0, DTB_OFS_TRACE, 0, DTB_BE_WORD);
        chk("restart", {16'h0, mem[0][15:0]}, v);
        @(posedge clk);
        sys_secured <= 1;
        bus(0, DTB_OFS_TRACE, 0, DTB_BE_WORD);
        chk("secured read", 0, v);
        sys_secured <= 0;
        bus(1, DTB_OFS_CTRL, 0, 4'hf);
        bus(0, DTB_OFS_TRACE, 0, DTB_BE_WORD);
        chk("source off", 0, v);
        $display("test session done");
        first = 1;
        fill = 0;
        bus(1, DTB_OFS_CTRL, 32'h21, 4'hf);
        burst(40);
        bus(1, DTB_OFS_CTRL, 32'h23, 4'hf);
        repeat (2) @(posedge clk);
        chk("no break", 1, brk_n);
        bus(0, DTB_OFS_STAT, 0, 4'hf);
        chk("wrap flag", 32'h10000, v & 32'h30000);
        readout();
        $display("test wrap done");
        bus(1, DTB_OFS_CTRL, 32'h39, 4'hf);
        bus(1, DTB_OFS_CTRL, 32'h3b, 4'hf);
        repeat (2) @(posedge clk);
        chk("begin early", 1, brk_n);
        chk("tracing", 1, trace_active);
        for (int k = 0; k <= D; k++) put({12'(k + 5), 6'h3});
        @(posedge clk);
        pc_req <= 0;
        repeat (4) @(posedge clk);
        chk("begin full", 2, brk_n);
        chk("trace stop", 0, trace_active);
        $display("test begin align done");
        bus(1, DTB_OFS_CTRL, 32'h11, 4'hf);
        hit(1);
        chk("direct break", 3, brk_n);
        bus(1, DTB_OFS_CTRL, 32'h11, 4'hf);
        background_monitor <= 1;
        hit(1);
        chk("monitor", 3, brk_n);
        background_monitor <= 0;
        bus(1, DTB_OFS_CTRL, 32'h111, 4'hf);
        hit(0);
        chk("tag addr", {14'h0, 18'h23456}, {14'h0, seen_addr});
        chk("tag break", 4, brk_n);
        $display("test breakpoints done");
        wrap_up();
    end
endmodule : dtb_debug_tb
